// [rtl/dwp_map.vh]
// Purpose: constants for the dual wiper serial shift port
// Assumes: included by the port module only
// Notes: positions are shift register bit indices
`ifndef DWP_MAP_VH
`define DWP_MAP_VH
`define DWP_SR_WIDTH 17
`define DWP_CODE_WIDTH 8
`define DWP_STACK_BIT 0
`define DWP_SECOND_MSB 1
`define DWP_SECOND_LSB 8
`define DWP_FIRST_MSB 9
`define DWP_FIRST_LSB 16
`define DWP_CLK_NS 20
`define DWP_COUT_MIN_NS 50
`define DWP_COUT_CYCLES ((`DWP_COUT_MIN_NS + `DWP_CLK_NS - 1) / `DWP_CLK_NS)
`endif

// [rtl/dwp_serial_port.v]
// Purpose: serial control port of a dual 256-tap potentiometer, sampled on the system clock
// Assumes: port enable, serial clock and data come from outside and are synchronised here
// Notes: the wiper codes have no reset value; sys_rst only clears control state
`timescale 1ns/1ns
`include "dwp_map.vh"
module dwp_serial_port #(
   parameter SR_WIDTH = `DWP_SR_WIDTH,
   parameter CODE_WIDTH = `DWP_CODE_WIDTH
) (
   input wire clock,
   input wire sys_rst,
   input wire portEnable,
   input wire serialClock,
   input wire serialData,
   output reg cascadeOut,
   output reg [CODE_WIDTH-1:0] firstWiperTerminal,
   output reg [CODE_WIDTH-1:0] secondWiperTerminal,
   output reg stackSelect,
   output reg [CODE_WIDTH:0] stackedTap
);
   localparam integer COUT_INT = `DWP_COUT_CYCLES;
   localparam [31:0] COUT_VEC = COUT_INT;
   localparam [3:0] COUT_CYCLES = COUT_VEC[3:0];

   // bit-reverse so code msb (lower shift position) lands in code bit 7
   function [CODE_WIDTH-1:0] takeCode;
      input [SR_WIDTH-1:0] sr;
      input integer msbPos;
      integer i;
      begin
         takeCode = {CODE_WIDTH{1'b0}};
         for (i = 0; i < CODE_WIDTH; i = i + 1) begin
            takeCode[CODE_WIDTH-1-i] = sr[msbPos+i];
         end
      end
   endfunction

   reg enMeta_q, enSync_q, enPrev_q;
   reg clkMeta_q, clkSync_q, clkPrev_q;
   reg datMeta_q, datSync_q;
   reg armed_q;
   reg [SR_WIDTH-1:0] shiftReg_q;
   reg [3:0] coutCnt_q;
   reg pendingBit_q;
   wire clkRise;
   wire enFall;
   wire enRise;

   always @(posedge clock) begin
      enMeta_q <= portEnable;
      enSync_q <= enMeta_q;
      clkMeta_q <= serialClock;
      clkSync_q <= clkMeta_q;
      datMeta_q <= serialData;
      datSync_q <= datMeta_q;
      // tracks through reset, so an enable held high across reset is never seen as a rise
      enPrev_q <= enSync_q;
      if (sys_rst) begin
         clkPrev_q <= 1'b0;
      end else begin
         clkPrev_q <= clkSync_q;
      end
   end

   assign clkRise = clkSync_q & ~clkPrev_q;
   assign enRise = enSync_q & ~enPrev_q;
   assign enFall = ~enSync_q & enPrev_q;

   // armed only by a low-to-high enable edge, so an enable stuck high at reset shifts nothing
   always @(posedge clock) begin
      if (sys_rst) begin
         armed_q <= 1'b0;
      end else if (!enSync_q) begin
         armed_q <= 1'b0;
      end else if (enRise) begin
         armed_q <= 1'b1;
      end
   end

   // register content is left unreset: wipers power up unknown
   always @(posedge clock) begin
      if (armed_q && enSync_q && clkRise) begin
         // new bit enters at the top, so the first bit sent ends at position 0
         shiftReg_q <= {datSync_q, shiftReg_q[SR_WIDTH-1:1]};
      end
   end

   // outgoing bit waits at least the cascade delay before showing
   always @(posedge clock) begin
      if (sys_rst) begin
         coutCnt_q <= 4'h0;
         pendingBit_q <= 1'b0;
         cascadeOut <= 1'b0;
      end else if (!enSync_q || (enSync_q && !armed_q)) begin
         coutCnt_q <= 4'h0;
         cascadeOut <= shiftReg_q[`DWP_STACK_BIT];
      end else if (clkRise) begin
         // next bit to leave is position 0 after this shift, which a chained device samples
         pendingBit_q <= shiftReg_q[`DWP_STACK_BIT+1];
         coutCnt_q <= COUT_CYCLES;
      end else if (coutCnt_q == 4'h1) begin
         coutCnt_q <= 4'h0;
         cascadeOut <= pendingBit_q;
      end else if (coutCnt_q != 4'h0) begin
         coutCnt_q <= coutCnt_q - 4'h1;
      end
   end

   // wipers change only on the enable falling edge
   always @(posedge clock) begin
      if (enFall) begin
         firstWiperTerminal <= takeCode(shiftReg_q, `DWP_FIRST_MSB);
         secondWiperTerminal <= takeCode(shiftReg_q, `DWP_SECOND_MSB);
         stackSelect <= shiftReg_q[`DWP_STACK_BIT];
      end
   end

   // stacked tap: 512 positions, upper half is the second wiper
   always @(posedge clock) begin
      if (stackSelect) begin
         stackedTap <= {1'b1, secondWiperTerminal};
      end else begin
         stackedTap <= {1'b0, firstWiperTerminal};
      end
   end
endmodule // dwp_serial_port

// [tb/dwp_port_monitor.sv]
// Purpose: port checker. Assumes: enable low until the first load. Notes: idle until then, wipers start unknown
`timescale 1ns/1ns
module dwp_port_monitor (input wire clock, sys_rst, portEnable, serialClock, serialData, cascadeOut, stackSelect,
   input wire [7:0] firstWiperTerminal, secondWiperTerminal, input wire [8:0] stackedTap);
   reg [5:0] on_q = 6'h00;
   always @(posedge clock) on_q <= {on_q[4:0], on_q[0] | (!sys_rst && $fell(portEnable))};
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst || !on_q[5]);
   code_hold_a: assert property ($changed({firstWiperTerminal, secondWiperTerminal}) |-> !$past(portEnable, 2))
      else $error("code");
   sel_hold_a: assert property ($changed(stackSelect) |-> !$past(portEnable, 2)) else $error("sel");
   tap_sel_a: assert property (stackedTap[8] == $past(stackSelect)) else $error("tap");
   tap_code_a: assert property (stackedTap[7:0] == ($past(stackSelect) ?
      $past(secondWiperTerminal) : $past(firstWiperTerminal))) else $error("tap code");
   idle_out_a: assert property (!portEnable [*8] |-> cascadeOut == stackSelect) else $error("idle");
   idle_quiet_a: assert property (!portEnable [*8] |-> $stable(cascadeOut)) else $error("quiet");
   out_delay_a: assert property (portEnable && $rose(serialClock) |-> $stable(cascadeOut) [*4]) else $error("early");
   first_out_a: assert property ($rose(portEnable) |-> cascadeOut == stackSelect) else $error("first");
   cover property ($fell(portEnable));
   cover property (stackSelect);
   cover property (portEnable && $rose(serialClock));
endmodule // dwp_port_monitor

// [tb/dwp_ctl_model.sv]
// Purpose: controller model. Assumes: called just after a clock edge. Notes: released data shows its last bit inverted
`timescale 1ns/1ns
module dwp_ctl_model (output reg portEnable, serialClock, serialData);
   initial {portEnable, serialClock, serialData} = 3'h0;
   task frame(input [33:0] bits, input integer n, input en);
      portEnable = en;
      #160;
      for (integer i = n - 1; i >= 0; i = i - 1) begin
         serialData = bits[i];
         #80 serialClock = 1'b1;
         #80 serialClock = 1'b0;
      end
      #80 {portEnable, serialData} = {1'b0, ~serialData};
      #320;
   endtask
endmodule // dwp_ctl_model

// [tb/tb_dwp_serial_port.sv]
// Purpose: bench for the serial port. Assumes: frames from the model. Notes: every fourth frame keeps enable low
`timescale 1ns/1ns
module tb_dwp_serial_port;
   reg clock = 1'b0, sys_rst = 1'b1;
   reg [63:0] r;
   reg [26:0] got;
   wire portEnable, serialClock, serialData, cascadeOut, stackSelect;
   wire [7:0] firstWiperTerminal, secondWiperTerminal;
   wire [8:0] stackedTap;
   integer seed = 32'h8628, failures = 0, checked = 0, k, e, x, q[$];
   integer refReg = 0, refCount = 0;
   initial forever #10 clock = ~clock;
   dwp_ctl_model dwp_ctl_model_inst (.*);
   dwp_serial_port dwp_serial_port_inst (.*);
   // reference register: a chained device samples cascade at each serial rise and must see position 0
   always @(posedge serialClock) begin
      if (portEnable) begin
         if (refCount >= 17) begin
            checked = checked + 1;
            if (cascadeOut !== refReg[0]) begin
               failures = failures + 1;
               $display("wrong value at %0t: %h %h", $time, cascadeOut, refReg[0]);
            end
         end
         refReg = (refReg >> 1) | (serialData << 16);
         refCount = refCount + 1;
      end
   end
   task final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000 failures = failures + 1;
      final_report;
   end
   initial begin
      #71 sys_rst = 1'b0;
      for (k = 0; k < 12; k = k + 1) begin
         r = {$random(seed), $random(seed)};
         dwp_ctl_model_inst.frame(r[33:0], k % 3 == 2 ? 34 : 17, k % 4 != 3);
         if (k % 4 != 3) q.push_back(r[16:0]);
         e = q[$];
         x = (e >> 8 & 256 | (e > 65535 ? e >> 8 : e) & 255) * 262144 + (e >> 16) * 196608 + (e & 65535);
         got = {stackedTap, stackSelect, cascadeOut, secondWiperTerminal, firstWiperTerminal};
         checked = checked + 1;
         failures = failures + (got !== x);
         if (got !== x) $display("wrong value at %0t: %h %h", $time, got, x);
      end
      final_report;
   end
endmodule // tb_dwp_serial_port
bind dwp_serial_port dwp_port_monitor dwp_port_monitor_inst (.*);
